// ==== include/iadcs_pkg.sv ====
// Purpose: Types of the incremental ADC sequencer
// Assumes: Used with iadcs_regs.svh
// Notes: One-hot states
package iadcs_pkg;
	typedef enum logic [4:0] {
		IADCS_IDLE = 5'b00001,
		IADCS_INIT = 5'b00010,
		IADCS_ELEM = 5'b00100,
		IADCS_QUANT = 5'b01000,
		IADCS_TERM = 5'b10000
	} iadcs_state_t;
	typedef struct packed {
		logic modulator_run;
		logic offset_invert;
		logic [3:0] stage_enable;
		logic sample_strobe;
	} iadcs_ana_ctrl_t;
endpackage

// ==== include/iadcs_regs.svh ====
// Purpose: Register offsets, fields, reset values and timing constants of the incremental ADC sequencer
// Assumes: Plain register port, 8-bit word addresses
// Notes: Functional notes follow
// Functional notes
// RL1: Start or alternate trigger begins conversion
// RL2: Programmed elementary conversions then one quantisation
// RL3: Elementary conversion lasts OVERSAMPLING_RATIO plus one periods
// RL4: Result is mean of elementary results
// RL5: Alternate offset polarity between elementary conversions
// RL6: Rate select divides RC by 4/8/32 or 8kHz
// RL7: OVERSAMPLING_RATIO is two to three plus field
// RL8: Elementary count is two to field
// RL9: Software should program two or more conversions
// RL10: Resolution is twice log OVERSAMPLING_RATIO plus log count
// RL11: Resolution truncated to sixteen bits
// RL12: Total time count times OVERSAMPLING_RATIO+1 plus one
// RL13: Extra clock cycles before and after sequence
// RL14: Continuous mode runs conversions back to back
// RL15: Software may choose resolution beyond sixteen bits
// RL16: Enable bit zero gates the converter
// RL17: Result is sixteen-bit two's complement
// RL18: Out-of-range results saturate to extremes
// RL19: Done pulse and result update after quantisation
// RL20: Trigger during conversion restarts the sequence
`ifndef IADCS_REGS_SVH
`define IADCS_REGS_SVH
`define IADCS_ADDR_CFG0 8'h00
`define IADCS_ADDR_CFG1 8'h01
`define IADCS_ADDR_RES_LO 8'h02
`define IADCS_ADDR_RES_HI 8'h03
`define IADCS_ADDR_STAT 8'h04
`define IADCS_CFG0_START 0
`define IADCS_CFG0_ALT 1
`define IADCS_CFG0_OSR_LO 2
`define IADCS_CFG0_NELC_LO 5
`define IADCS_CFG0_CONT 7
`define IADCS_CFG1_RATE_LO 0
`define IADCS_CFG1_EN_LO 2
`define IADCS_CFG0_RST 8'h00
`define IADCS_CFG1_RST 8'h00
`define IADCS_SLOW_HZ 8000
`define IADCS_CLK_HZ 200000000
`define IADCS_SLOW_DIV (`IADCS_CLK_HZ / `IADCS_SLOW_HZ)
`define IADCS_EDGE_CYCLES 2
`define IADCS_RES_MAX 16'h7fff
`define IADCS_RES_MIN 16'h8000
`endif

// ==== logic/iadcs_sequencer.sv ====
// Purpose: Sequencer, rate divider, averager and register port of an incremental ADC
// Assumes: rc_osc_clk_in and mod_bit_in are asynchronous to clk
// Notes: Modulator bit is +1/-1 per sampling period
//
// Our own choices: the strobed register port and the address map.
`timescale 1ns/100ps
`include "iadcs_regs.svh"
module iadcs_sequencer
	import iadcs_pkg::*;
#(
	parameter int SLOW_DIV = `IADCS_SLOW_DIV
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	input wire logic rc_osc_clk_in,
	input wire logic mod_bit_in,
	output iadcs_ana_ctrl_t ana_ctrl,
	output logic conv_done,
	output logic busy
);
	logic [7:0] cfg0_q;
	logic [7:0] cfg1_q;
	logic [15:0] result_q;
	logic [7:0] rdata_q;
	logic [1:0] rc_sync_q;
	logic [1:0] mod_sync_q;
	logic rc_prev_q;
	logic [4:0] rc_cnt_q;
	logic [15:0] slow_cnt_q;
	logic tick_q;
	iadcs_state_t state_q;
	logic [10:0] period_cnt_q;
	logic [3:0] elem_cnt_q;
	logic [2:0] edge_cnt_q;
	logic polarity_q;
	logic signed [15:0] integ_q;
	logic signed [19:0] sum_q;
	logic done_q;
	logic [2:0] osr_sel;
	logic [1:0] nelc_sel;
	logic [1:0] rate_sel;
	logic [10:0] osr_val;
	logic [3:0] nelc_val;
	logic trigger;
	logic rc_rise;
	logic [4:0] rc_div;
	logic signed [19:0] sum_next;
	logic signed [20:0] mean_full;
	logic [15:0] mean_sat;

	assign osr_sel = cfg0_q[`IADCS_CFG0_OSR_LO +: 3];
	assign nelc_sel = cfg0_q[`IADCS_CFG0_NELC_LO +: 2];
	assign rate_sel = cfg1_q[`IADCS_CFG1_RATE_LO +: 2];
	assign osr_val = 11'h008 << osr_sel; // RL7
	assign nelc_val = 4'h1 << nelc_sel; // RL8
	assign trigger = reg_wr && (reg_addr == `IADCS_ADDR_CFG0) &&
		(reg_wdata[`IADCS_CFG0_START] || reg_wdata[`IADCS_CFG0_ALT]); // RL1
	assign rc_rise = rc_sync_q[1] && !rc_prev_q;

	// Register writes; trigger bits self clear
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cfg0_q <= `IADCS_CFG0_RST;
			cfg1_q <= `IADCS_CFG1_RST;
		end else begin
			cfg0_q[1:0] <= 2'h0;
			if (reg_wr && reg_addr == `IADCS_ADDR_CFG0) begin
				cfg0_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == `IADCS_ADDR_CFG1) begin
				cfg1_q <= {2'h0, reg_wdata[5:0]};
			end
		end
	end

	// Register reads, data one cycle later
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_q <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				`IADCS_ADDR_CFG0: rdata_q <= cfg0_q;
				`IADCS_ADDR_CFG1: rdata_q <= cfg1_q;
				`IADCS_ADDR_RES_LO: rdata_q <= result_q[7:0];
				`IADCS_ADDR_RES_HI: rdata_q <= result_q[15:8];
				`IADCS_ADDR_STAT: rdata_q <= {7'h00, state_q != IADCS_IDLE};
				default: rdata_q <= 8'h00;
			endcase
		end else begin
			rdata_q <= 8'h00;
		end
	end
	assign reg_rdata = rdata_q;

	// Pin synchronisers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rc_sync_q <= 2'h0;
			mod_sync_q <= 2'h0;
			rc_prev_q <= 1'b0;
		end else begin
			rc_sync_q <= {rc_sync_q[0], rc_osc_clk_in};
			mod_sync_q <= {mod_sync_q[0], mod_bit_in};
			rc_prev_q <= rc_sync_q[1];
		end
	end

	// Sampling rate divider
	always_comb begin
		case (rate_sel)
			2'b00: rc_div = 5'd3; // RL6
			2'b01: rc_div = 5'd7; // RL6
			default: rc_div = 5'd31; // RL6
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rc_cnt_q <= 5'h0;
			slow_cnt_q <= 16'h0;
			tick_q <= 1'b0;
		end else begin
			tick_q <= 1'b0;
			if (rate_sel == 2'b11) begin
				if (slow_cnt_q >= 16'(SLOW_DIV - 1)) begin
					slow_cnt_q <= 16'h0;
					tick_q <= 1'b1; // RL6
				end else begin
					slow_cnt_q <= slow_cnt_q + 16'h1;
				end
			end else if (rc_rise) begin
				if (rc_cnt_q >= rc_div) begin
					rc_cnt_q <= 5'h0;
					tick_q <= 1'b1;
				end else begin
					rc_cnt_q <= rc_cnt_q + 5'h1;
				end
			end
		end
	end

	// Polarity is already undone per period, so results simply accumulate
	assign sum_next = sum_q + 20'(integ_q); // RL4
	// Mean: divide by count, scale to 16-bit full scale
	always_comb begin
		mean_full = 21'(sum_q) >>> nelc_sel; // RL4
		mean_full = mean_full <<< (5'd13 - 5'(osr_sel)); // RL10 RL11
		if (mean_full > 21'sd32767) begin
			mean_sat = `IADCS_RES_MAX; // RL18
		end else if (mean_full < -21'sd32768) begin
			mean_sat = `IADCS_RES_MIN; // RL18
		end else begin
			mean_sat = mean_full[15:0]; // RL17
		end
	end

	// Sequencer
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= IADCS_IDLE;
			period_cnt_q <= 11'h0;
			elem_cnt_q <= 4'h0;
			edge_cnt_q <= 3'h0;
			polarity_q <= 1'b0;
			integ_q <= 16'sh0;
			sum_q <= 20'sh0;
			done_q <= 1'b0;
			result_q <= 16'h0;
		end else begin
			done_q <= 1'b0;
			if (!cfg1_q[`IADCS_CFG1_EN_LO]) begin
				state_q <= IADCS_IDLE; // RL16
			end else if (trigger) begin
				state_q <= IADCS_INIT; // RL1 RL20
				edge_cnt_q <= 3'h0;
				elem_cnt_q <= 4'h0;
				period_cnt_q <= 11'h0;
				polarity_q <= 1'b0;
				integ_q <= 16'sh0;
				sum_q <= 20'sh0;
			end else begin
				case (state_q)
					IADCS_IDLE: begin
						state_q <= IADCS_IDLE;
					end
					IADCS_INIT: begin
						edge_cnt_q <= edge_cnt_q + 3'h1;
						if (edge_cnt_q == 3'(`IADCS_EDGE_CYCLES - 1)) begin
							state_q <= IADCS_ELEM; // RL13
						end
					end
					IADCS_ELEM: begin
						if (tick_q) begin
							if (period_cnt_q == osr_val) begin
								period_cnt_q <= 11'h0; // RL3
								sum_q <= sum_next;
								integ_q <= 16'sh0;
								polarity_q <= !polarity_q; // RL5
								elem_cnt_q <= elem_cnt_q + 4'h1;
								if (elem_cnt_q == nelc_val - 4'h1) begin
									state_q <= IADCS_QUANT; // RL2
								end
							end else begin
								period_cnt_q <= period_cnt_q + 11'h1;
								if (period_cnt_q != 11'h0) begin
									integ_q <= (mod_sync_q[1] ^ polarity_q) ? integ_q + 16'sh1 : integ_q - 16'sh1; // RL5
								end
							end
						end
					end
					IADCS_QUANT: begin
						if (tick_q) begin
							state_q <= IADCS_TERM; // RL2 RL12
							edge_cnt_q <= 3'h0;
						end
					end
					IADCS_TERM: begin
						edge_cnt_q <= edge_cnt_q + 3'h1;
						if (edge_cnt_q == 3'(`IADCS_EDGE_CYCLES - 1)) begin
							result_q <= mean_sat; // RL19
							done_q <= 1'b1; // RL19
							sum_q <= 20'sh0;
							elem_cnt_q <= 4'h0;
							polarity_q <= 1'b0;
							edge_cnt_q <= 3'h0;
							state_q <= cfg0_q[`IADCS_CFG0_CONT] ? IADCS_INIT : IADCS_IDLE; // RL14
						end
					end
					default: state_q <= IADCS_IDLE;
				endcase
			end
		end
	end

	// Analogue control outputs
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ana_ctrl <= '0;
			busy <= 1'b0;
		end else begin
			// Modulator also runs for the final quantisation period
			ana_ctrl.modulator_run <= (state_q == IADCS_ELEM) || (state_q == IADCS_QUANT); // RL2
			ana_ctrl.offset_invert <= polarity_q; // RL5
			ana_ctrl.stage_enable <= cfg1_q[`IADCS_CFG1_EN_LO +: 4]; // RL16
			ana_ctrl.sample_strobe <= tick_q;
			busy <= (state_q != IADCS_IDLE);
		end
	end
	assign conv_done = done_q;
endmodule // iadcs_sequencer

// ==== test/iadcs_ana_model.sv ====
// Purpose: RC oscillator and modulator stand-in
// Assumes: Fixed input level, full scale
// Notes: Oscillator runs free
`timescale 1ns/100ps
module iadcs_ana_model
	import iadcs_pkg::*;
#(
	parameter int RC_HALF = 10
) (
	input wire logic level,
	input wire iadcs_ana_ctrl_t ana_ctrl,
	output logic rc_osc_clk_in,
	output logic mod_bit_in
);
	initial begin
		rc_osc_clk_in = 1'b0;
		forever #(RC_HALF) rc_osc_clk_in = ~rc_osc_clk_in;
	end
	assign mod_bit_in = level ^ ana_ctrl.offset_invert;
endmodule // iadcs_ana_model

// ==== test/iadcs_checker.sv ====
// Purpose: Port assertions of the sequencer
// Assumes: Enable tracked from register writes
// Notes: One clock domain
`timescale 1ns/100ps
module iadcs_checker
	import iadcs_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire iadcs_ana_ctrl_t ana_ctrl,
	input wire logic conv_done,
	input wire logic busy
);
	logic en_q;
	logic [3:0] stg_q;
	wire c1_wr = reg_wr && reg_addr == 8'h01;
	wire trig = reg_wr && reg_addr == 8'h00 && reg_wdata[1:0] != 2'b00;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			en_q <= 1'b0;
			stg_q <= 4'h0;
		end else if (c1_wr) begin
			en_q <= reg_wdata[2];
			stg_q <= reg_wdata[5:2];
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence go_s; trig && en_q; endsequence
	sequence init_s; !ana_ctrl.modulator_run ##1 !ana_ctrl.modulator_run; endsequence
	go_busy_a: assert property (go_s |-> ##2 busy) else $error("no start");
	off_idle_a: assert property (trig && !en_q && !busy |=> !busy) else $error("start while off");
	abort_idle_a: assert property (c1_wr && !reg_wdata[2] |-> ##[1:3] !busy) else $error("no abort");
	stage_en_a: assert property (!c1_wr && !$past(c1_wr) |-> ana_ctrl.stage_enable == stg_q)
		else $error("stage enables wrong");
	rd_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("stray read data");
	done_pulse_a: assert property (conv_done |=> !conv_done) else $error("done too long");
	done_busy_a: assert property (conv_done |-> $past(busy)) else $error("done while idle");
	strobe_pulse_a: assert property (ana_ctrl.sample_strobe |=> !ana_ctrl.sample_strobe)
		else $error("strobe too long");
	init_quiet_a: assert property ($rose(busy) |-> init_s) else $error("no init gap");
endmodule // iadcs_checker
bind iadcs_sequencer iadcs_checker chk_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.ana_ctrl(ana_ctrl), .conv_done(conv_done), .busy(busy));

// ==== test/tb_top.sv ====
// Purpose: Register level tests of the sequencer
// Assumes: SLOW_DIV of 4, RC period 4 clocks
// Notes: Results saturate at full scale
`timescale 1ns/100ps
module tb_top
	import iadcs_pkg::*;
;
	logic clk, rst_n, reg_wr, reg_rd, level, rc, mb, conv_done, busy;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	iadcs_ana_ctrl_t ana_ctrl;
	int n_mismatch, compares, cyc, k, m;
	int sp_tbl[4] = '{16, 32, 128, 4};
	logic [2:0] o_tbl[4] = '{3'd0, 3'd1, 3'd3, 3'd7};
	logic [1:0] n_tbl[4] = '{2'd0, 2'd1, 2'd2, 2'd0};
	iadcs_sequencer #(.SLOW_DIV(4)) dut_u (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.rc_osc_clk_in(rc), .mod_bit_in(mb), .ana_ctrl(ana_ctrl), .conv_done(conv_done), .busy(busy));
	iadcs_ana_model mdl_u (.level(level), .ana_ctrl(ana_ctrl), .rc_osc_clk_in(rc), .mod_bit_in(mb));
	task automatic results();
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		compares++;
		if (g !== e) begin
			n_mismatch++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		chk({8'h00, reg_rdata}, {8'h00, e});
	endtask
	task automatic wdone(input int e);
		m = 0;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
			if (ana_ctrl.sample_strobe === 1'b1 && ana_ctrl.modulator_run === 1'b1)
				m++;
		end while (conv_done !== 1'b1 && k < 20000);
		chk(16'(m), 16'(e));
	endtask
	task automatic sp();
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
		end while (ana_ctrl.sample_strobe !== 1'b1 && k < 1000);
	endtask
	task automatic run(input logic [2:0] o, input logic [1:0] n, input logic lv, input logic [1:0] t);
		level <= lv;
		wr(8'h00, {1'b0, n, o, t});
		wdone((1 << n) * ((1 << (3 + o)) + 1) + 1);
		rd(8'h02, lv ? 8'hff : 8'h00);
		rd(8'h03, lv ? 8'h7f : 8'h80);
	endtask
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	always @(posedge clk) begin
		cyc++;
		if (cyc == 90000) begin
			n_mismatch++;
			results();
		end
	end
	initial begin
		rst_n = 1'b0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		level = 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rd(8'h00, 8'h00);
		rd(8'h01, 8'h00);
		rd(8'h02, 8'h00);
		rd(8'h05, 8'h00);
		wr(8'h00, 8'h01);
		rd(8'h04, 8'h00);
		wr(8'h01, 8'h3c);
		rd(8'h01, 8'h3c);
		wr(8'h00, 8'h1d);
		for (int c = 0; c < 4; c++) begin
			wr(8'h01, 8'h3c | 8'(c));
			sp();
			sp();
			chk(16'(k), 16'(sp_tbl[c]));
		end
		wr(8'h01, 8'h00);
		repeat (3) @(posedge clk);
		rd(8'h04, 8'h00);
		wr(8'h01, 8'h3c);
		wr(8'h00, 8'h61);
		repeat (200) @(posedge clk);
		rd(8'h04, 8'h01);
		run(3'd0, 2'd3, 1'b0, 2'b10);
		for (int i = 0; i < 4; i++)
			run(o_tbl[i], n_tbl[i], i[0], 2'(1 + i % 2));
		level <= 1'b1;
		wr(8'h00, 8'h81);
		wdone(10);
		wdone(10);
		wr(8'h01, 8'h00);
		repeat (3) @(posedge clk);
		rd(8'h04, 8'h00);
		results();
	end
endmodule // tb_top
